// ==== verilog/mcsp_core_sfr.sv ====
// Core special-function registers: stack pointer, data pointers, program counter,
// digital I/O ports, external move stretch, flash erase and EEPROM register entries.
// Assumes the instruction engine drives the request ports on ref_clk_i and
// that pins arrive asynchronously.
`timescale 1ns/1ns
`default_nettype none
`include "mcsp_core_regs.svh"

module mcsp_core_sfr (
  // Clock and reset.
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  // Special-function access from the instruction engine.
  input wire mcsp_core_pkg::mcsp_sfr_req_t sfr_req_i,
  output logic [7:0] sfr_rdata_o,
  output logic sfr_rvalid_o,
  // Stack events.
  input wire logic stack_push_i,
  input wire logic stack_pop_i,
  output logic [7:0] stack_addr_o,
  // Program counter events.
  input wire logic opcode_fetch_i,
  input wire logic code_operand_read_i,
  input wire logic pc_load_i,
  input wire logic [15:0] pc_load_value_i,
  output logic [15:0] program_counter_o,
  // Data pointers and external data move requests.
  input wire logic data_pointer_sel_i,
  input wire logic xmove_start_i,
  input wire logic xmove_wr_i,
  input wire logic [7:0] xmove_wdata_i,
  output logic [15:0] data_pointer_zero_o,
  output logic [15:0] data_pointer_one_o,
  output logic xmove_busy_o,
  output logic xmove_done_o,
  output logic [7:0] xmove_rdata_o,
  // External memory bus.
  input wire logic [7:0] mem_rdata_i,
  output logic [15:0] mem_addr_o,
  output logic mem_addr_en_o,
  output logic mem_rd_o,
  output logic mem_wr_o,
  output logic [7:0] mem_wdata_o,
  // Digital I/O pins, three ports of eight.
  input wire logic [23:0] digital_io_pin_i,
  output logic [23:0] digital_io_pin_o,
  output logic [23:0] digital_io_pin_oe_o,
  output logic [23:0] digital_io_level_o,
  // Flash erase and bank control.
  output logic flash_erase_start_o,
  output logic [7:0] flash_erase_code_o,
  output logic flash_page_valid_o,
  output logic [6:0] flash_page_erase_address_o,
  output logic [2:0] flash_bank_select_o,
  // EEPROM interface registers.
  input wire logic [7:0] eeprom_status_i,
  output logic [7:0] eeprom_data_o,
  output logic [7:0] eeprom_control_o,
  output logic eeprom_control_wr_o
);

  // Register state.
  logic [7:0] stack_pointer_q;
  logic [7:0] ptr_low_q [2];
  logic [7:0] ptr_high_q [2];
  logic [15:0] program_counter_q;
  logic [7:0] port_latch_q [3];
  logic [7:0] port_dir_q [3];
  logic [2:0] stretch_q;
  logic [23:0] pin_level;
  logic [15:0] sel_ptr;
  mcsp_core_pkg::mcsp_xmove_req_t xreq;

  // Decodes an access to one offset; used by every register write below.
  function automatic logic hit(input logic [7:0] addr, input logic [7:0] off);
    hit = (addr == off);
  endfunction

  // Port offsets indexed by port number keep the per-port logic in one loop.
  function automatic logic [7:0] latch_off(input int p);
    case (p)
      0: latch_off = `MCSP_OFF_PORT0_LATCH;
      1: latch_off = `MCSP_OFF_PORT1_LATCH;
      default: latch_off = `MCSP_OFF_PORT2_LATCH;
    endcase
  endfunction

  function automatic logic [7:0] dir_off(input int p);
    case (p)
      0: dir_off = `MCSP_OFF_PORT0_DIR;
      1: dir_off = `MCSP_OFF_PORT1_DIR;
      default: dir_off = `MCSP_OFF_PORT2_DIR;
    endcase
  endfunction

  logic sfr_wr;
  logic sfr_rd;
  logic [7:0] sfr_addr;
  logic [7:0] sfr_wdata;
  assign sfr_wr = sfr_req_i.wr;
  assign sfr_rd = sfr_req_i.rd;
  assign sfr_addr = sfr_req_i.addr;
  assign sfr_wdata = sfr_req_i.wdata;

  // Stack pointer: a push increments first so the write lands above the old top.
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      stack_pointer_q <= `MCSP_RST_STACK_POINTER;
      stack_addr_o <= `MCSP_RST_STACK_POINTER;
    end else if (stack_push_i) begin
      stack_pointer_q <= stack_pointer_q + 8'h01;
      stack_addr_o <= stack_pointer_q + 8'h01;
    end else if (stack_pop_i) begin
      stack_pointer_q <= stack_pointer_q - 8'h01;
      stack_addr_o <= stack_pointer_q;
    end else if (sfr_wr && hit(sfr_addr, `MCSP_OFF_STACK_POINTER)) begin
      stack_pointer_q <= sfr_wdata;
      stack_addr_o <= sfr_wdata;
    end
  end

  // Data pointers: each byte has its own offset so firmware can load them piecewise.
  genvar d;
  generate
    for (d = 0; d < 2; d++) begin : g_ptr
      localparam logic [7:0] LO_OFF = d ? `MCSP_OFF_PTR1_LOW : `MCSP_OFF_PTR0_LOW;
      localparam logic [7:0] HI_OFF = d ? `MCSP_OFF_PTR1_HIGH : `MCSP_OFF_PTR0_HIGH;
      always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
          ptr_low_q[d] <= `MCSP_RST_PTR;
          ptr_high_q[d] <= `MCSP_RST_PTR;
        end else if (sfr_wr) begin
          if (hit(sfr_addr, LO_OFF)) begin
            ptr_low_q[d] <= sfr_wdata;
          end
          if (hit(sfr_addr, HI_OFF)) begin
            ptr_high_q[d] <= sfr_wdata;
          end
        end
      end
    end
  endgenerate

  // Pointer outputs come from the byte registers directly.
  assign data_pointer_zero_o = {ptr_high_q[0], ptr_low_q[0]};
  assign data_pointer_one_o = {ptr_high_q[1], ptr_low_q[1]};
  assign sel_ptr = data_pointer_sel_i ? data_pointer_one_o : data_pointer_zero_o;

  // Program counter: a load from a branch wins over a plain advance.
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      program_counter_q <= `MCSP_RST_PC;
    end else if (pc_load_i) begin
      program_counter_q <= pc_load_value_i;
    end else if (opcode_fetch_i || code_operand_read_i) begin
      program_counter_q <= program_counter_q + 16'h0001;
    end
  end
  assign program_counter_o = program_counter_q;

  // Ports: latch and direction per port; input pins are left undriven.
  genvar p;
  generate
    for (p = 0; p < 3; p++) begin : g_port
      always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
          port_latch_q[p] <= `MCSP_RST_PORT_LATCH;
          port_dir_q[p] <= `MCSP_RST_PORT_DIR;
        end else if (sfr_wr) begin
          if (hit(sfr_addr, latch_off(p))) begin
            port_latch_q[p] <= sfr_wdata;
          end
          if (hit(sfr_addr, dir_off(p))) begin
            port_dir_q[p] <= sfr_wdata;
          end
        end
      end
      assign digital_io_pin_o[8*p +: 8] = port_latch_q[p];
      assign digital_io_pin_oe_o[8*p +: 8] = port_dir_q[p];
    end
  endgenerate

  // Pin levels are synchronised and read back regardless of direction.
  mcsp_pin_sync #(
    .WIDTH(24)
  ) u_pin_sync (
    .ref_clk_i(ref_clk_i),
    .nrst_i(nrst_i),
    .pin_i(digital_io_pin_i),
    .level_o(pin_level)
  );
  assign digital_io_level_o = pin_level;

  // Stretch field; upper bits of the register read as zero.
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      stretch_q <= `MCSP_RST_STRETCH;
    end else if (sfr_wr && hit(sfr_addr, `MCSP_OFF_STRETCH_CTRL)) begin
      stretch_q <= sfr_wdata[`MCSP_STRETCH_MSB:`MCSP_STRETCH_LSB];
    end
  end

  // External data moves take their address from the selected data pointer.
  // One assignment drives the whole struct, so it has a single driver.
  assign xreq = {xmove_start_i, xmove_wr_i, sel_ptr, xmove_wdata_i};

  mcsp_xmove_seq u_xmove_seq (
    .ref_clk_i(ref_clk_i),
    .nrst_i(nrst_i),
    .req_i(xreq),
    .stretch_i(stretch_q),
    .mem_rdata_i(mem_rdata_i),
    .mem_addr_o(mem_addr_o),
    .mem_addr_en_o(mem_addr_en_o),
    .mem_rd_o(mem_rd_o),
    .mem_wr_o(mem_wr_o),
    .mem_wdata_o(mem_wdata_o),
    .busy_o(xmove_busy_o),
    .done_o(xmove_done_o),
    .rdata_o(xmove_rdata_o)
  );

  // Flash erase: a write issues a one-cycle start carrying the written code.
  // A page erase is only qualified while a fresh page address is armed.
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      flash_erase_start_o <= 1'b0;
      flash_erase_code_o <= 8'h00;
      flash_page_valid_o <= 1'b0;
      flash_page_erase_address_o <= `MCSP_RST_PAGE_ADDR;
      flash_bank_select_o <= `MCSP_RST_FLASH_BANK;
    end else begin
      flash_erase_start_o <= sfr_wr && hit(sfr_addr, `MCSP_OFF_FLASH_ERASE);
      if (sfr_wr && hit(sfr_addr, `MCSP_OFF_FLASH_ERASE)) begin
        flash_erase_code_o <= sfr_wdata;
      end
      if (sfr_wr && hit(sfr_addr, `MCSP_OFF_PAGE_ADDR)) begin
        flash_page_erase_address_o <= sfr_wdata[`MCSP_PAGE_MSB:0];
        flash_page_valid_o <= 1'b1;
      end else if (flash_erase_start_o) begin
        flash_page_valid_o <= 1'b0;
      end
      if (sfr_wr && hit(sfr_addr, `MCSP_OFF_FLASH_BANK)) begin
        flash_bank_select_o <= sfr_wdata[`MCSP_BANK_MSB:0];
      end
    end
  end

  // EEPROM registers; a control write is flagged so the interface can act on it.
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      eeprom_data_o <= `MCSP_RST_EEPROM;
      eeprom_control_o <= `MCSP_RST_EEPROM;
      eeprom_control_wr_o <= 1'b0;
    end else begin
      eeprom_control_wr_o <= sfr_wr && hit(sfr_addr, `MCSP_OFF_EEPROM_CTRL);
      if (sfr_wr && hit(sfr_addr, `MCSP_OFF_EEPROM_DATA)) begin
        eeprom_data_o <= sfr_wdata;
      end
      if (sfr_wr && hit(sfr_addr, `MCSP_OFF_EEPROM_CTRL)) begin
        eeprom_control_o <= sfr_wdata;
      end
    end
  end

  // Read mux, registered; unmapped offsets and the erase register read zero.
  logic [7:0] rd_mux;
  always_comb begin
    rd_mux = 8'h00;
    case (sfr_addr)
      `MCSP_OFF_PORT0_LATCH: rd_mux = pin_level[7:0];
      `MCSP_OFF_PORT1_LATCH: rd_mux = pin_level[15:8];
      `MCSP_OFF_PORT2_LATCH: rd_mux = pin_level[23:16];
      `MCSP_OFF_PORT0_DIR: rd_mux = port_dir_q[0];
      `MCSP_OFF_PORT1_DIR: rd_mux = port_dir_q[1];
      `MCSP_OFF_PORT2_DIR: rd_mux = port_dir_q[2];
      `MCSP_OFF_STACK_POINTER: rd_mux = stack_pointer_q;
      `MCSP_OFF_PTR0_LOW: rd_mux = ptr_low_q[0];
      `MCSP_OFF_PTR0_HIGH: rd_mux = ptr_high_q[0];
      `MCSP_OFF_PTR1_LOW: rd_mux = ptr_low_q[1];
      `MCSP_OFF_PTR1_HIGH: rd_mux = ptr_high_q[1];
      `MCSP_OFF_STRETCH_CTRL: rd_mux = {5'h00, stretch_q};
      `MCSP_OFF_EEPROM_DATA: rd_mux = eeprom_data_o;
      `MCSP_OFF_EEPROM_CTRL: rd_mux = eeprom_status_i;
      `MCSP_OFF_FLASH_BANK: rd_mux = {5'h00, flash_bank_select_o};
      `MCSP_OFF_PAGE_ADDR: rd_mux = {1'b0, flash_page_erase_address_o};
      default: rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sfr_rdata_o <= 8'h00;
      sfr_rvalid_o <= 1'b0;
    end else begin
      sfr_rvalid_o <= sfr_rd;
      if (sfr_rd) begin
        sfr_rdata_o <= rd_mux;
      end
    end
  end

endmodule // mcsp_core_sfr

`default_nettype wire

// ==== verilog/mcsp_core_regs.svh ====
// Register offsets, reset values and field layouts of the core special-function block.
// Assumes the special-function address space is 8 bits wide with 8-bit data.
`ifndef MCSP_CORE_REGS_SVH
`define MCSP_CORE_REGS_SVH

// Special-function offsets.
`define MCSP_OFF_PORT0_LATCH 8'h80
`define MCSP_OFF_STACK_POINTER 8'h81
`define MCSP_OFF_PTR0_LOW 8'h82
`define MCSP_OFF_PTR0_HIGH 8'h83
`define MCSP_OFF_PTR1_LOW 8'h84
`define MCSP_OFF_PTR1_HIGH 8'h85
`define MCSP_OFF_STRETCH_CTRL 8'h8e
`define MCSP_OFF_PORT1_LATCH 8'h90
`define MCSP_OFF_PORT1_DIR 8'h91
`define MCSP_OFF_FLASH_ERASE 8'h94
`define MCSP_OFF_EEPROM_DATA 8'h9e
`define MCSP_OFF_EEPROM_CTRL 8'h9f
`define MCSP_OFF_PORT2_LATCH 8'ha0
`define MCSP_OFF_PORT2_DIR 8'ha1
`define MCSP_OFF_PORT0_DIR 8'ha2
`define MCSP_OFF_FLASH_BANK 8'hb6
`define MCSP_OFF_PAGE_ADDR 8'hb7

// Reset values.
`define MCSP_RST_STACK_POINTER 8'h07
`define MCSP_RST_PTR 8'h00
`define MCSP_RST_PC 16'h0000
`define MCSP_RST_PORT_LATCH 8'hff
`define MCSP_RST_PORT_DIR 8'h00
`define MCSP_RST_STRETCH 3'h1
`define MCSP_RST_PAGE_ADDR 7'h00
`define MCSP_RST_FLASH_BANK 3'h0
`define MCSP_RST_EEPROM 8'h00

// Field layouts.
`define MCSP_STRETCH_MSB 2
`define MCSP_STRETCH_LSB 0
`define MCSP_BANK_MSB 2
`define MCSP_PAGE_MSB 6

// Cycle counts of an external data move, in MPU clocks, relative to the stretch value.
`define MCSP_RD_EXTRA 4'h1
`define MCSP_WR_EXTRA 4'h2
`define MCSP_WR_STROBE_MIN 4'h1

`endif

// ==== verilog/mcsp_core_pkg.sv ====
// Types shared by the core special-function block and its helpers.
// Assumes the constants header is included where numbers are needed.
`default_nettype none

package mcsp_core_pkg;

  // One access from the instruction engine to the special-function space.
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } mcsp_sfr_req_t;

  // Request to run one external data move cycle.
  typedef struct packed {
    logic start;
    logic wr;
    logic [15:0] addr;
    logic [7:0] wdata;
  } mcsp_xmove_req_t;

  // Sequencer of the external data move cycle.
  typedef enum logic [0:0] {
    MCSP_XM_IDLE = 1'b0,
    MCSP_XM_BUSY = 1'b1
  } mcsp_xm_state_t;

endpackage

`default_nettype wire

// ==== verilog/mcsp_pin_sync.sv ====
// Two-stage synchroniser for the digital I/O pin levels.
// Assumes pins change asynchronously to ref_clk_i.
`timescale 1ns/1ns
`default_nettype none

module mcsp_pin_sync #(
  parameter int WIDTH = 24
) (
  // Clock and reset.
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  // Raw pins and synchronised levels.
  input wire logic [WIDTH-1:0] pin_i,
  output logic [WIDTH-1:0] level_o
);

  logic [WIDTH-1:0] meta_q;

  // Each bit gets its own pair of flops; only the second stage is ever read.
  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : g_bit
      always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
          meta_q[g] <= 1'b0;
          level_o[g] <= 1'b0;
        end else begin
          meta_q[g] <= pin_i[g];
          level_o[g] <= meta_q[g];
        end
      end
    end
  endgenerate

endmodule // mcsp_pin_sync

`default_nettype wire

// ==== verilog/mcsp_xmove_seq.sv ====
// External data move cycle sequencer: address, read strobe and write strobe widths.
// Assumes a new start is only given while idle; starts during a cycle are ignored.
`timescale 1ns/1ns
`default_nettype none
`include "mcsp_core_regs.svh"

module mcsp_xmove_seq (
  // Clock and reset.
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  // Request and stretch setting.
  input wire mcsp_core_pkg::mcsp_xmove_req_t req_i,
  input wire logic [2:0] stretch_i,
  // External memory side.
  input wire logic [7:0] mem_rdata_i,
  output logic [15:0] mem_addr_o,
  output logic mem_addr_en_o,
  output logic mem_rd_o,
  output logic mem_wr_o,
  output logic [7:0] mem_wdata_o,
  // Completion.
  output logic busy_o,
  output logic done_o,
  output logic [7:0] rdata_o
);

  mcsp_core_pkg::mcsp_xm_state_t state_q;
  logic [3:0] idx_q;
  logic [3:0] total_q;
  logic [3:0] wlen_q;
  logic is_wr_q;
  logic [3:0] nxt;
  logic [3:0] stretch_w;

  assign stretch_w = {1'b0, stretch_i};
  assign nxt = idx_q + 4'h1;
  assign busy_o = (state_q == mcsp_core_pkg::MCSP_XM_BUSY);

  // The stretch value is sampled at start so a rewrite mid-cycle cannot tear a strobe.
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_q <= mcsp_core_pkg::MCSP_XM_IDLE;
      idx_q <= 4'h0;
      total_q <= 4'h0;
      wlen_q <= 4'h0;
      is_wr_q <= 1'b0;
      mem_addr_o <= 16'h0000;
      mem_addr_en_o <= 1'b0;
      mem_rd_o <= 1'b0;
      mem_wr_o <= 1'b0;
      mem_wdata_o <= 8'h00;
      done_o <= 1'b0;
      rdata_o <= 8'h00;
    end else begin
      done_o <= 1'b0;
      case (state_q)
        mcsp_core_pkg::MCSP_XM_IDLE: begin
          if (req_i.start) begin
            state_q <= mcsp_core_pkg::MCSP_XM_BUSY;
            idx_q <= 4'h0;
            is_wr_q <= req_i.wr;
            total_q <= stretch_w + (req_i.wr ? `MCSP_WR_EXTRA : `MCSP_RD_EXTRA);
            wlen_q <= (stretch_w < 4'h2) ? `MCSP_WR_STROBE_MIN : stretch_w;
            mem_addr_o <= req_i.addr;
            mem_wdata_o <= req_i.wdata;
            mem_addr_en_o <= 1'b1;
            mem_rd_o <= !req_i.wr;
          end
        end
        mcsp_core_pkg::MCSP_XM_BUSY: begin
          idx_q <= nxt;
          if (nxt == total_q) begin
            state_q <= mcsp_core_pkg::MCSP_XM_IDLE;
            mem_addr_en_o <= 1'b0;
            mem_rd_o <= 1'b0;
            mem_wr_o <= 1'b0;
            done_o <= 1'b1;
            if (!is_wr_q) begin
              rdata_o <= mem_rdata_i;
            end
          end else begin
            // The write strobe opens one cycle after the address settles.
            mem_wr_o <= is_wr_q && (nxt <= wlen_q);
          end
        end
        default: begin
          state_q <= mcsp_core_pkg::MCSP_XM_IDLE;
        end
      endcase
    end
  end

endmodule // mcsp_xmove_seq

`default_nettype wire

// ==== dv/mcsp_core_sfr_properties.sv ====
// Checker for the core special-function block, bound to its top ports.
// Assumes one clock domain with an active-low asynchronous reset.
`timescale 1ns/1ns
`default_nettype none

module mcsp_core_sfr_properties (
  // Clock and reset.
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  // Watched ports.
  input wire mcsp_core_pkg::mcsp_sfr_req_t sfr_req_i,
  input wire logic sfr_rvalid_o,
  input wire logic stack_push_i,
  input wire logic stack_pop_i,
  input wire logic [7:0] stack_addr_o,
  input wire logic opcode_fetch_i,
  input wire logic code_operand_read_i,
  input wire logic pc_load_i,
  input wire logic [15:0] program_counter_o,
  input wire logic xmove_start_i,
  input wire logic xmove_wr_i,
  input wire logic xmove_busy_o,
  input wire logic xmove_done_o,
  input wire logic mem_addr_en_o,
  input wire logic mem_rd_o,
  input wire logic mem_wr_o,
  input wire logic [23:0] digital_io_pin_i,
  input wire logic [23:0] digital_io_level_o
);
  default clocking dcb @(posedge ref_clk_i); endclocking
  default disable iff (!nrst_i);

  logic [2:0] s_q;
  logic [2:0] ls_q;
  logic w_q;
  logic [3:0] ae_q;
  logic [3:0] rd_q;
  logic [3:0] wr_q;
  logic [7:0] top_q;

  // Stack pointer mirror; after a pop the stack address is not the pointer, so track it here.
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      top_q <= 8'h07;
    end else if (stack_push_i) begin
      top_q <= top_q + 8'h01;
    end else if (stack_pop_i) begin
      top_q <= top_q - 8'h01;
    end else if (sfr_req_i.wr && sfr_req_i.addr == 8'h81) begin
      top_q <= sfr_req_i.wdata;
    end
  end

  // Mirror of the stretch field; only writes change it.
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s_q <= 3'h1;
    end else if (sfr_req_i.wr && sfr_req_i.addr == 8'h8e) begin
      s_q <= sfr_req_i.wdata[2:0];
    end
  end

  // Stretch and kind are frozen at the start, so a later write cannot skew the widths.
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ls_q <= 3'h1;
      w_q <= 1'b0;
    end else if (xmove_start_i && !xmove_busy_o) begin
      ls_q <= s_q;
      w_q <= xmove_wr_i;
    end
  end

  // Run lengths of the address and strobe pulses.
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ae_q <= 4'h0;
      rd_q <= 4'h0;
      wr_q <= 4'h0;
    end else begin
      ae_q <= mem_addr_en_o ? ae_q + 4'h1 : 4'h0;
      rd_q <= mem_rd_o ? rd_q + 4'h1 : 4'h0;
      wr_q <= mem_wr_o ? wr_q + 4'h1 : 4'h0;
    end
  end

  chk_sp_reset: assert property (
    $rose(nrst_i) |-> stack_addr_o == 8'h07 && program_counter_o == 16'h0000)
    else $error("reset value of stack or counter wrong");
  chk_push_inc: assert property (
    stack_push_i |=> stack_addr_o == $past(top_q) + 8'h01)
    else $error("push did not step the stack pointer");
  chk_pc_step: assert property (
    (opcode_fetch_i || code_operand_read_i) && !pc_load_i
    |=> program_counter_o == $past(program_counter_o) + 16'h0001)
    else $error("program counter did not advance");
  chk_rd_strobe: assert property (
    $fell(mem_rd_o) |-> rd_q == {1'b0, ls_q} + 4'h1)
    else $error("read strobe width wrong");
  chk_addr_width: assert property (
    $fell(mem_addr_en_o) |-> xmove_done_o && ae_q == {1'b0, ls_q} + (w_q ? 4'h2 : 4'h1))
    else $error("address width wrong");
  chk_wr_strobe: assert property (
    $fell(mem_wr_o) |-> wr_q == (ls_q < 3'h2 ? 4'h1 : {1'b0, ls_q}))
    else $error("write strobe width wrong");
  chk_read_answer: assert property (
    sfr_rvalid_o == $past(sfr_req_i.rd))
    else $error("read answer not one cycle later");
  chk_pin_sync: assert property (
    $past(nrst_i) && $past(nrst_i, 2) |-> digital_io_level_o == $past(digital_io_pin_i, 2))
    else $error("pin level not two cycles behind pins");
endmodule // mcsp_core_sfr_properties

`default_nettype wire

// ==== dv/mcsp_xmem_model.sv ====
// External data memory model on the far side of the move sequencer.
// Assumes address and strobes come from registers of the block.
`timescale 1ns/1ns
`default_nettype none

module mcsp_xmem_model (
  // Clock.
  input wire logic ref_clk_i,
  // Memory bus from the block.
  input wire logic [15:0] mem_addr_i,
  input wire logic mem_rd_i,
  input wire logic mem_wr_i,
  input wire logic [7:0] mem_wdata_i,
  output logic [7:0] mem_rdata_o
);
  logic [7:0] mem_q [256];
  logic [7:0] idle_q = 8'h00;

  // Writes land on the edge while the strobe is high.
  always @(posedge ref_clk_i) begin
    if (mem_wr_i) begin
      mem_q[mem_addr_i[7:0]] <= mem_wdata_i;
    end
    idle_q <= ~mem_rdata_o;
  end

  // Outside a read the bus shows the inverse of its last value, so it never holds a stale value.
  assign mem_rdata_o = mem_rd_i ? mem_q[mem_addr_i[7:0]] : idle_q;
endmodule // mcsp_xmem_model

`default_nettype wire

// ==== dv/mcsp_core_sfr_tb.sv ====
// Self-checking bench for the core special-function block.
// Assumes the block, its checker and the memory model are compiled first.
`timescale 1ns/1ns
`default_nettype none

module mcsp_core_sfr_tb;
  logic ref_clk_i = 1'b0;
  logic nrst_i = 1'b0;
  mcsp_core_pkg::mcsp_sfr_req_t req = '0;
  logic push = 1'b0;
  logic pop = 1'b0;
  logic ld = 1'b0;
  logic dsel = 1'b1;
  logic [15:0] ldv = 16'h0000;
  logic [7:0] est = 8'h00;
  logic fetch = 1'b0;
  logic oper = 1'b0;
  logic mv = 1'b0;
  logic mv_wr = 1'b0;
  logic [7:0] mv_d = 8'h00;
  logic [23:0] ext = 24'h000000;
  logic [7:0] rdata, mrd, xrd, mwd, sp, ecode, edat, ectl;
  logic [15:0] pc, dp0, dp1, ma;
  logic [23:0] pin_o, oe, lvl, pins;
  logic rvalid, busy, done, ae, rd, wr, erase, pvalid, ewr;
  logic [6:0] page;
  logic [2:0] bank;
  int n_mismatch = 0;
  int n_checks = 0;

  // Clock of 4 ns.
  always #2 ref_clk_i = ~ref_clk_i;

  // Pin level: driver where enabled, outside level elsewhere.
  assign pins = (oe & pin_o) | (~oe & ext);

  mcsp_core_sfr dut (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .sfr_req_i(req),
    .sfr_rdata_o(rdata), .sfr_rvalid_o(rvalid), .stack_push_i(push), .stack_pop_i(pop),
    .stack_addr_o(sp), .opcode_fetch_i(fetch), .code_operand_read_i(oper), .pc_load_i(ld),
    .pc_load_value_i(ldv), .program_counter_o(pc), .data_pointer_sel_i(dsel),
    .xmove_start_i(mv), .xmove_wr_i(mv_wr), .xmove_wdata_i(mv_d), .data_pointer_zero_o(dp0),
    .data_pointer_one_o(dp1), .xmove_busy_o(busy), .xmove_done_o(done), .xmove_rdata_o(xrd),
    .mem_rdata_i(mrd), .mem_addr_o(ma), .mem_addr_en_o(ae), .mem_rd_o(rd), .mem_wr_o(wr),
    .mem_wdata_o(mwd), .digital_io_pin_i(pins), .digital_io_pin_o(pin_o),
    .digital_io_pin_oe_o(oe), .digital_io_level_o(lvl), .flash_erase_start_o(erase),
    .flash_erase_code_o(ecode), .flash_page_valid_o(pvalid),
    .flash_page_erase_address_o(page), .flash_bank_select_o(bank), .eeprom_status_i(est),
    .eeprom_data_o(edat), .eeprom_control_o(ectl), .eeprom_control_wr_o(ewr));

  mcsp_xmem_model u_mem (.ref_clk_i(ref_clk_i), .mem_addr_i(ma), .mem_rd_i(rd),
    .mem_wr_i(wr), .mem_wdata_i(mwd), .mem_rdata_o(mrd));

  task automatic wrap_up();
    $display("checks %0d, mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic tick();
    @(posedge ref_clk_i);
    #1;
  endtask

  task automatic sfr_wr(input logic [7:0] a, input logic [7:0] d);
    tick();
    req = {a, d, 1'b1, 1'b0};
    tick();
    req = '0;
  endtask

  task automatic sfr_rd(input logic [7:0] a, input logic [7:0] e);
    tick();
    req = {a, 8'h00, 1'b0, 1'b1};
    tick();
    req = '0;
    chk({rvalid, rdata}, {1'b1, e});
  endtask

  // One external move; widths are counted cycle by cycle, with a bounded wait.
  task automatic xfer(input logic w, input logic [7:0] d, input logic [3:0] s);
    int na, nr, nw, k;
    na = 0;
    nr = 0;
    nw = 0;
    tick();
    mv = 1'b1;
    mv_wr = w;
    mv_d = d;
    for (k = 0; k < 20 && !done; k++) begin
      tick();
      mv = 1'b0;
      na += ae;
      nr += rd;
      nw += wr;
      if (k == 0) chk(busy, 1'b1);
      if (k == 1) chk(ma, dsel ? 16'h5678 : 16'h1234);
    end
    if (!done) begin
      n_mismatch++;
      wrap_up();
    end else begin
      chk(busy, 1'b0);
      chk(na, w ? s + 2 : s + 1);
      chk(nr, w ? 0 : s + 1);
      chk(nw, w ? (s < 2 ? 1 : s) : 0);
      if (!w) chk(xrd, d);
    end
  endtask

  task automatic t_reset();
    chk(pc, 16'h0000);
    sfr_rd(8'h81, 8'h07);
    sfr_rd(8'h8e, 8'h01);
    sfr_rd(8'hb7, 8'h00);
    sfr_rd(8'h83, 8'h00);
  endtask

  task automatic t_stack_pc();
    for (int i = 1; i < 3; i++) begin
      tick();
      push = 1'b1;
      tick();
      push = 1'b0;
      chk(sp, 8'h07 + i[7:0]);
    end
    sfr_rd(8'h81, 8'h09);
    tick();
    fetch = 1'b1;
    tick();
    fetch = 1'b0;
    oper = 1'b1;
    tick();
    oper = 1'b0;
    chk(pc, 16'h0002);
  endtask

  task automatic t_data_pointer_zero();
    sfr_wr(8'h82, 8'h34);
    sfr_wr(8'h83, 8'h12);
    sfr_wr(8'h84, 8'h78);
    sfr_wr(8'h85, 8'h56);
    chk(dp0, 16'h1234);
    chk(dp1, 16'h5678);
    sfr_rd(8'h84, 8'h78);
    sfr_rd(8'h85, 8'h56);
  endtask

  task automatic t_ports();
    ext = 24'h3cc35a;
    sfr_wr(8'ha2, 8'h0f);
    sfr_wr(8'h80, 8'ha5);
    chk({pin_o[7:0], oe[7:0]}, 16'ha50f);
    tick();
    tick();
    chk(lvl[7:0], 8'h55);
    sfr_rd(8'h80, 8'h55);
    sfr_rd(8'h90, 8'hc3);
  endtask

  task automatic t_moves();
    for (int s = 0; s < 8; s++) begin
      sfr_wr(8'h8e, s[7:0]);
      xfer(1'b1, 8'h30 + s[7:0], s[3:0]);
      xfer(1'b0, 8'h30 + s[7:0], s[3:0]);
    end
    sfr_wr(8'h8e, 8'h01);
  endtask

  task automatic t_flash();
    sfr_wr(8'hb7, 8'hff);
    chk({pvalid, page}, 8'hff);
    sfr_wr(8'h94, 8'haa);
    chk({erase, ecode}, 9'h1aa);
    tick();
    chk({erase, pvalid}, 2'b00);
    sfr_rd(8'h94, 8'h00);
  endtask

  // Pop then push, load over fetch, side registers, pointer zero, then a reset in mid-run.
  task automatic t_misc();
    est = 8'h3c;
    pop = 1'b1;
    tick();
    pop = 1'b0;
    push = 1'b1;
    chk(sp, 8'h09);
    tick();
    push = 1'b0;
    chk(sp, 8'h09);
    ld = 1'b1;
    fetch = 1'b1;
    ldv = 16'habcd;
    tick();
    ld = 1'b0;
    fetch = 1'b0;
    chk(pc, 16'habcd);
    sfr_wr(8'hb6, 8'hfd);
    sfr_wr(8'h9e, 8'h5a);
    sfr_wr(8'h9f, 8'ha7);
    chk({ewr, ectl}, 9'h1a7);
    sfr_rd(8'hb6, 8'h05);
    sfr_rd(8'h9f, 8'h3c);
    chk({bank, edat}, 11'h55a);
    dsel = 1'b0;
    xfer(1'b1, 8'h6e, 4'h1);
    xfer(1'b0, 8'h6e, 4'h1);
    nrst_i = 1'b0;
    tick();
    nrst_i = 1'b1;
    t_reset();
  endtask

  // Reset for eight cycles, then the scenarios in turn.
  initial begin
    repeat (8) @(posedge ref_clk_i);
    #1;
    nrst_i = 1'b1;
    t_reset();
    t_stack_pc();
    t_data_pointer_zero();
    t_ports();
    t_moves();
    t_flash();
    t_misc();
    wrap_up();
  end
endmodule // mcsp_core_sfr_tb

bind mcsp_core_sfr mcsp_core_sfr_properties u_props (.ref_clk_i, .nrst_i, .sfr_req_i,
  .sfr_rvalid_o, .stack_push_i, .stack_pop_i, .stack_addr_o, .opcode_fetch_i,
  .code_operand_read_i,
  .pc_load_i, .program_counter_o, .xmove_start_i, .xmove_wr_i, .xmove_busy_o,
  .xmove_done_o, .mem_addr_en_o, .mem_rd_o, .mem_wr_o, .digital_io_pin_i,
  .digital_io_level_o);

`default_nettype wire
